// ===== core/taf_thermal_throttle.sv
// thermal assist unit and instruction fetch throttle
// assumes supervisor state and the external interrupt enable come from
// the core, and an asynchronous analog comparator result
//
// What this block does
// - forward interval field in throttle bits 23-30
// - throttle bit 31 enables fetch throttling
// - throttle writes act on forwarding immediately
// - throttle register at special register 1019
// - bit 0 flags threshold crossed, read-only
// - bit 1 flags comparison result valid
// - bits 2-8 hold threshold in degrees
// - bit 29 picks above or below
// - bit 30 and core enable gate interrupt
// - flag still updates with interrupt disabled
// - bit 31 clear excludes threshold from comparison
// - compare only when enabled and one valid
// - single threshold or time-multiplexed dual threshold
// - threshold write clears its valid, restarts
// - control write clears both valids, restarts
// - control bit 31 is global compare enable
// - wait sample interval clocks before sampling
// - thermal registers at 1020, 1021, 1022
`timescale 1ns/1ns
`default_nettype none
module taf_thermal_throttle (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // special-register moves
  input wire logic spr_supervisor,
  input wire logic spr_write,
  input wire logic spr_read,
  input wire taf_pkg::taf_spr_t spr_num,
  input wire taf_pkg::taf_word_t spr_wdata,
  output var taf_pkg::taf_word_t spr_rdata,
  output logic spr_ack,
  output logic spr_error,
  // interrupt
  input wire logic external_irq_enable,
  output logic thermal_irq,
  // sensor comparator
  input wire logic sensor_above,
  output logic [6:0] dac_threshold,
  // instruction forwarding
  input wire logic fetch_req,
  output logic fetch_forward
);
  import taf_pkg::*;

  // -----------------------------------------------------------------
  // register port decode
  // -----------------------------------------------------------------
  logic sup_wr;
  logic sup_rd;
  logic wr_ft;
  logic wr_ctrl;
  logic [1:0] wr_th;
  logic restart;
  logic mapped;

  // unimplemented sample address registers take writes silently
  function automatic logic spr_mapped(taf_spr_t num, logic wr);
    return (num inside {SPR_THROTTLE, SPR_THR_A, SPR_THR_B, SPR_CTRL})
      || (wr && (num inside {SPR_SDA, SPR_USDA}));
  endfunction

  // write strobes, supervisor only
  assign sup_wr = spr_supervisor && spr_write;
  assign sup_rd = spr_supervisor && spr_read;
  assign mapped = spr_mapped(spr_num, spr_write);
  assign wr_ft = sup_wr && (spr_num == SPR_THROTTLE);
  assign wr_th[0] = sup_wr && (spr_num == SPR_THR_A);
  assign wr_th[1] = sup_wr && (spr_num == SPR_THR_B);
  assign wr_ctrl = sup_wr && (spr_num == SPR_CTRL);
  assign restart = wr_ctrl || (|wr_th);

  // -----------------------------------------------------------------
  // fetch throttle
  // -----------------------------------------------------------------
  logic ft_en;
  logic [7:0] ft_fi;
  logic [7:0] gap;
  logic eff_en;
  logic [7:0] eff_fi;

  // throttle control register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ft_en <= 1'b0;
      ft_fi <= FI_RESET;
    end else if (wr_ft) begin
      ft_en <= spr_wdata[FT_EN];
      ft_fi <= spr_wdata[FT_FI_MSB:FT_FI_LSB];
    end
  end

  // write data bypass so a new setting acts in its own cycle
  assign eff_en = wr_ft ? spr_wdata[FT_EN] : ft_en;
  assign eff_fi = wr_ft ? spr_wdata[FT_FI_MSB:FT_FI_LSB] : ft_fi;

  // clocks since the last forward, saturating
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gap <= GAP_MAX;
    end else if (fetch_req && fetch_forward) begin
      gap <= 8'h01;
    end else if (gap != GAP_MAX) begin
      gap <= gap + 8'h01;
    end
  end

  // unthrottled when disabled, else spaced by the interval
  assign fetch_forward = !eff_en || (gap >= eff_fi);

  // -----------------------------------------------------------------
  // thermal registers
  // -----------------------------------------------------------------
  logic tc_en;
  logic [12:0] tc_sample_interval;
  logic th_v [2];
  logic th_ie [2];
  logic th_dir [2];
  logic th_tin [2];
  logic th_tiv [2];
  logic [6:0] th_lvl [2];
  taf_word_t th_word [2];
  logic above_meta;
  logic above_sync;
  taf_state_t state;
  logic sel;
  logic [12:0] cnt;
  logic run;
  logic sample;

  // control register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tc_en <= 1'b0;
      tc_sample_interval <= SAMPLE_INTERVAL_RESET;
    end else if (wr_ctrl) begin
      tc_en <= spr_wdata[TC_EN];
      tc_sample_interval <= spr_wdata[TC_SAMPLE_INTERVAL_MSB:TC_SAMPLE_INTERVAL_LSB];
    end
  end

  // per-threshold fields and status
  for (genvar g = 0; g < 2; g++) begin : g_thr
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        th_v[g] <= 1'b0;
        th_ie[g] <= 1'b0;
        th_dir[g] <= 1'b0;
        th_lvl[g] <= LVL_RESET;
        th_tin[g] <= 1'b0;
        th_tiv[g] <= 1'b0;
      end else if (wr_th[g]) begin
        th_v[g] <= spr_wdata[TH_V];
        th_ie[g] <= spr_wdata[TH_IE];
        th_dir[g] <= spr_wdata[TH_DIR];
        th_lvl[g] <= spr_wdata[TH_LVL_MSB:TH_LVL_LSB];
        th_tiv[g] <= 1'b0;
      end else if (wr_ctrl) begin
        th_tiv[g] <= 1'b0;
      end else if (sample && (sel == 1'(g))) begin
        // result recorded whether or not the interrupt is enabled
        th_tin[g] <= th_dir[g] ? !above_sync : above_sync;
        th_tiv[g] <= 1'b1;
      end
    end
    // read view, reserved bits read as zero
    assign th_word[g] = {th_v[g], th_ie[g], th_dir[g], 20'h0_0000,
                         th_lvl[g], th_tiv[g], th_tin[g]};
  end

  // -----------------------------------------------------------------
  // comparison sequencer
  // -----------------------------------------------------------------
  // next register to compare: the other one if valid, else this one
  function automatic logic pick_next(logic v0, logic v1, logic cur);
    return (cur ? v0 : v1) ? !cur : cur;
  endfunction

  // comparator result synchroniser
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      above_meta <= 1'b0;
      above_sync <= 1'b0;
    end else begin
      above_meta <= sensor_above;
      above_sync <= above_meta;
    end
  end

  assign run = tc_en && (th_v[0] || th_v[1]);
  assign sample = (state == TAF_SETTLE) && (cnt >= tc_sample_interval) && !restart;

  // settle timer and time-multiplexed selection
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= TAF_IDLE;
      sel <= 1'b0;
      cnt <= 13'h0000;
    end else if (!run || restart) begin
      state <= TAF_IDLE;
      cnt <= 13'h0000;
    end else begin
      case (state)
        TAF_IDLE: begin
          state <= TAF_SETTLE;
          sel <= pick_next(th_v[0], th_v[1], 1'b1);
          cnt <= 13'h0000;
        end
        TAF_SETTLE: begin
          if (sample) begin
            sel <= pick_next(th_v[0], th_v[1], sel);
            cnt <= 13'h0000;
          end else begin
            cnt <= cnt + 13'h0001;
          end
        end
        default: begin
          state <= TAF_IDLE;
        end
      endcase
    end
  end

  // threshold presented to the converter
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dac_threshold <= LVL_RESET;
    end else begin
      dac_threshold <= th_lvl[sel];
    end
  end

  // interrupt request, masked by the core enable
  assign thermal_irq = external_irq_enable
    && ((th_ie[0] && th_tiv[0] && th_tin[0])
    || (th_ie[1] && th_tiv[1] && th_tin[1]));

  // -----------------------------------------------------------------
  // read data and answers
  // -----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      spr_rdata <= 32'h0000_0000;
      spr_ack <= 1'b0;
      spr_error <= 1'b0;
    end else begin
      spr_ack <= spr_supervisor && (spr_write || spr_read) && mapped;
      spr_error <= (spr_write || spr_read) && !(spr_supervisor && mapped);
      if (sup_rd && mapped) begin
        case (spr_num)
          SPR_THROTTLE: spr_rdata <= {ft_en, ft_fi, 23'h00_0000};
          SPR_THR_A: spr_rdata <= th_word[0];
          SPR_THR_B: spr_rdata <= th_word[1];
          SPR_CTRL: spr_rdata <= {tc_en, tc_sample_interval, 18'h0_0000};
          default: spr_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  sequence s_arm;
    (state == TAF_IDLE) && run && !restart && (tc_sample_interval == 13'h0003);
  endsequence
  sequence s_quiet;
    !restart [*4];
  endsequence

  a_fwd_spacing: assert property (
    (fetch_req && fetch_forward && ft_en && (ft_fi >= 8'h02) && !wr_ft)
    ##1 !wr_ft |-> !fetch_forward)
    else $error("forward came before the interval");
  a_fwd_free: assert property (
    !ft_en && !wr_ft |-> fetch_forward)
    else $error("forward held while throttle off");
  a_ctl_immediate: assert property (
    wr_ft && !spr_wdata[FT_EN] |-> fetch_forward)
    else $error("disable did not act at once");
  a_read_throttle: assert property (
    sup_rd && (spr_num == SPR_THROTTLE) |=> spr_ack
    && (spr_rdata == {$past(ft_en), $past(ft_fi), 23'h00_0000}))
    else $error("throttle read mismatch");
  a_cross_above: assert property (
    sample && !sel && !th_dir[0] |=> th_tin[0] == $past(above_sync))
    else $error("above crossing flag wrong");
  a_tiv_set: assert property (
    sample && !sel |=> th_tiv[0])
    else $error("valid flag not set after sample");
  a_cross_below: assert property (
    sample && sel && th_dir[1] |=> th_tin[1] == !$past(above_sync))
    else $error("below crossing flag wrong");
  a_irq_gate: assert property (
    thermal_irq |-> external_irq_enable
    && ((th_ie[0] && th_v[0]) || (th_ie[1] && th_v[1])))
    else $error("interrupt without enable");
  a_quiet_update: assert property (
    sample && sel && !th_ie[1] |=> th_tiv[1] && (!thermal_irq || th_ie[0]))
    else $error("silent comparison not recorded");
  a_skip_invalid: assert property (
    sample |-> (sel ? th_v[1] : th_v[0]))
    else $error("invalid threshold compared");
  a_stop_idle: assert property (
    !run |=> state == TAF_IDLE)
    else $error("comparison running while disabled");
  a_dual_mux: assert property (
    sample && th_v[0] && th_v[1] |=> sel != $past(sel))
    else $error("dual mode did not alternate");
  a_wr_restart: assert property (
    wr_th[0] |=> !th_tiv[0] && (state == TAF_IDLE))
    else $error("threshold write did not restart");
  a_ctrl_clear: assert property (
    wr_ctrl |=> !th_tiv[0] && !th_tiv[1])
    else $error("control write left a valid flag");
  a_sample_wait: assert property (
    s_arm ##1 s_quiet |-> sample)
    else $error("sample not taken after interval");
  a_spr_decode: assert property (
    wr_ctrl |=> spr_ack && !spr_error)
    else $error("control register not answered");
  a_irq_drop: assert property (
    wr_ctrl |=> !thermal_irq)
    else $error("interrupt held after restart");
endmodule // taf_thermal_throttle
`default_nettype wire

// ===== core/taf_pkg.sv
// shared constants and types of the thermal assist and fetch throttle
// assumes a 32-bit special-register move port on the processor clock
package taf_pkg;
  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef logic [9:0] taf_spr_t;
  typedef logic [31:0] taf_word_t;
  typedef enum logic [1:0] {
    TAF_IDLE = 2'b01,
    TAF_SETTLE = 2'b10
  } taf_state_t;
  // -----------------------------------------------------------------
  // special register numbers
  // -----------------------------------------------------------------
  localparam taf_spr_t SPR_THROTTLE = 10'h3fb;
  localparam taf_spr_t SPR_THR_A = 10'h3fc;
  localparam taf_spr_t SPR_THR_B = 10'h3fd;
  localparam taf_spr_t SPR_CTRL = 10'h3fe;
  localparam taf_spr_t SPR_SDA = 10'h3bf;
  localparam taf_spr_t SPR_USDA = 10'h3af;
  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int TH_TIN = 0;
  localparam int TH_TIV = 1;
  localparam int TH_LVL_LSB = 2;
  localparam int TH_LVL_MSB = 8;
  localparam int TH_DIR = 29;
  localparam int TH_IE = 30;
  localparam int TH_V = 31;
  localparam int FT_FI_LSB = 23;
  localparam int FT_FI_MSB = 30;
  localparam int FT_EN = 31;
  localparam int TC_SAMPLE_INTERVAL_LSB = 18;
  localparam int TC_SAMPLE_INTERVAL_MSB = 30;
  localparam int TC_EN = 31;
  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] FI_RESET = 8'h00;
  localparam logic [6:0] LVL_RESET = 7'h00;
  localparam logic [12:0] SAMPLE_INTERVAL_RESET = 13'h0000;
  localparam logic [7:0] GAP_MAX = 8'hff;
endpackage

// ===== verif/taf_sensor_model.sv
// behavioural junction sensor, dac and comparator for the thermal unit
// assumes the bench sets the die temperature in whole degrees
`timescale 1ns/1ns
`default_nettype none
module taf_sensor_model (
  // threshold from the unit
  input wire logic [6:0] dac_threshold,
  // die temperature from the bench
  input wire logic [6:0] temp_c,
  // comparator result
  output logic sensor_above
);
  // equality reads as not above, the comparator's own call
  assign sensor_above = temp_c > dac_threshold;
endmodule // taf_sensor_model
`default_nettype wire

// ===== verif/taf_thermal_throttle_bench.sv
// self-checking bench for the thermal assist unit and fetch throttle
// assumes the sensor model file is compiled before this one
`timescale 1ns/1ns
`default_nettype none
module taf_thermal_throttle_bench;
  import taf_pkg::*;
  // -----------------------------------------------------------------
  // signals and instances
  // -----------------------------------------------------------------
  logic clock, resetn, spr_supervisor, spr_write, spr_read;
  logic external_irq_enable, fetch_req;
  logic spr_ack, spr_error, thermal_irq, sensor_above, fetch_forward;
  logic [6:0] dac_threshold, temp_c;
  taf_spr_t spr_num;
  taf_word_t spr_wdata, spr_rdata, rd;
  int bad_count, check_count;
  localparam taf_word_t CTRL_ON = 32'h800c_0000; // enable, interval 3
  taf_thermal_throttle dut_u (.clock(clock), .resetn(resetn),
    .spr_supervisor(spr_supervisor), .spr_write(spr_write), .spr_read(spr_read),
    .spr_num(spr_num), .spr_wdata(spr_wdata), .spr_rdata(spr_rdata),
    .spr_ack(spr_ack), .spr_error(spr_error),
    .external_irq_enable(external_irq_enable), .thermal_irq(thermal_irq),
    .sensor_above(sensor_above), .dac_threshold(dac_threshold),
    .fetch_req(fetch_req), .fetch_forward(fetch_forward));
  taf_sensor_model sens_u (.dac_threshold(dac_threshold), .temp_c(temp_c),
    .sensor_above(sensor_above));
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic chk(input string n, input taf_word_t seen, input taf_word_t exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // reserved bits always written as zero
  function automatic taf_word_t thw(input logic v, ie, dir, input logic [6:0] t);
    return {v, ie, dir, 20'h0_0000, t, 2'b00};
  endfunction
  // one move, answer looked at in the cycle after the taking edge
  task automatic acc(input logic w, sup, input taf_spr_t num, input taf_word_t d,
                     input logic err);
    @(posedge clock);
    spr_write <= w;
    spr_read <= !w;
    spr_supervisor <= sup;
    spr_num <= num;
    spr_wdata <= d;
    @(posedge clock);
    spr_write <= 1'b0;
    spr_read <= 1'b0;
    #1;
    chk("ack", {31'h0, spr_ack}, {31'h0, !err});
    chk("error", {31'h0, spr_error}, {31'h0, err});
    rd = spr_rdata;
  endtask
  task automatic rdchk(input string n, input taf_spr_t num, input taf_word_t exp);
    acc(1'b0, 1'b1, num, 32'h0000_0000, 1'b0);
    chk(n, rd, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_regs;
    chk("forward at reset", {31'h0, fetch_forward}, 32'h0000_0001);
    rdchk("throttle", SPR_THROTTLE, 32'h0000_0000);
    rdchk("thr a", SPR_THR_A, 32'h0000_0000);
    rdchk("thr b", SPR_THR_B, 32'h0000_0000);
    rdchk("ctrl", SPR_CTRL, 32'h0000_0000);
    acc(1'b1, 1'b0, SPR_THROTTLE, 32'h8180_0000, 1'b1);
    acc(1'b0, 1'b1, SPR_SDA, 32'h0000_0000, 1'b1);
    acc(1'b1, 1'b1, SPR_SDA, 32'hffff_ffff, 1'b0);
    acc(1'b1, 1'b1, SPR_USDA, 32'hffff_ffff, 1'b0);
    rdchk("throttle kept", SPR_THROTTLE, 32'h0000_0000);
    $display("test regs done");
  endtask
  task automatic t_throttle;
    taf_word_t ones;
    taf_word_t w;
    for (int i = 0; i < 2; i++) begin
      w = i ? 32'h8080_0000 : 32'h8180_0000; // interval 3, then 1
      acc(1'b1, 1'b1, SPR_THROTTLE, w, 1'b0);
      ones = 0;
      repeat (9) begin
        @(posedge clock);
        #1;
        ones = ones + fetch_forward;
      end
      chk("forwards", ones, i ? 32'h0000_0009 : 32'h0000_0003);
      rdchk("throttle", SPR_THROTTLE, w);
    end
    acc(1'b1, 1'b1, SPR_THROTTLE, 32'h0180_0000, 1'b0);
    chk("forward off", {31'h0, fetch_forward}, 32'h0000_0001);
    $display("test throttle done");
  endtask
  task automatic t_single;
    temp_c <= 7'h3c; // 60 degrees
    acc(1'b1, 1'b1, SPR_THR_A, thw(1, 1, 0, 7'h32), 1'b0);
    acc(1'b1, 1'b1, SPR_CTRL, CTRL_ON, 1'b0);
    settle(14);
    chk("dac", {25'h0, dac_threshold}, 32'h0000_0032);
    chk("irq on", {31'h0, thermal_irq}, 32'h0000_0001);
    rdchk("a above", SPR_THR_A, thw(1, 1, 0, 7'h32) | 3);
    rdchk("ctrl", SPR_CTRL, CTRL_ON);
    @(posedge clock);
    external_irq_enable <= 1'b0;
    settle(1);
    chk("irq masked", {31'h0, thermal_irq}, 32'h0000_0000);
    @(posedge clock);
    external_irq_enable <= 1'b1;
    acc(1'b1, 1'b1, SPR_THR_A, thw(1, 1, 1, 7'h32), 1'b0);
    chk("irq restart", {31'h0, thermal_irq}, 32'h0000_0000);
    // crossed bit keeps the last result, meaningless until valid returns
    rdchk("a cleared", SPR_THR_A, thw(1, 1, 1, 7'h32) | 1);
    settle(14);
    rdchk("a below no", SPR_THR_A, thw(1, 1, 1, 7'h32) | 2);
    acc(1'b1, 1'b1, SPR_THR_A, thw(1, 0, 1, 7'h32), 1'b0);
    temp_c <= 7'h28; // 40 degrees
    settle(14);
    rdchk("a below", SPR_THR_A, thw(1, 0, 1, 7'h32) | 3);
    chk("irq off", {31'h0, thermal_irq}, 32'h0000_0000);
    $display("test single done");
  endtask
  task automatic t_dual;
    temp_c <= 7'h3c; // 60 degrees
    acc(1'b1, 1'b1, SPR_THR_A, thw(1, 0, 0, 7'h32), 1'b0);
    acc(1'b1, 1'b1, SPR_THR_B, thw(1, 0, 0, 7'h46), 1'b0);
    settle(30);
    rdchk("a dual", SPR_THR_A, thw(1, 0, 0, 7'h32) | 3);
    rdchk("b dual", SPR_THR_B, thw(1, 0, 0, 7'h46) | 2);
    acc(1'b1, 1'b1, SPR_CTRL, CTRL_ON, 1'b0);
    rdchk("a ctrl clr", SPR_THR_A, thw(1, 0, 0, 7'h32) | 1);
    rdchk("b ctrl clr", SPR_THR_B, thw(1, 0, 0, 7'h46));
    acc(1'b1, 1'b1, SPR_THR_A, thw(0, 0, 0, 7'h32), 1'b0);
    settle(30);
    rdchk("a excluded", SPR_THR_A, thw(0, 0, 0, 7'h32) | 1);
    rdchk("b alone", SPR_THR_B, thw(1, 0, 0, 7'h46) | 2);
    acc(1'b1, 1'b1, SPR_CTRL, 32'h000c_0000, 1'b0);
    settle(30);
    rdchk("b halted", SPR_THR_B, thw(1, 0, 0, 7'h46));
    $display("test dual done");
  endtask
  // -----------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // -----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    resetn = 1'b0;
    spr_supervisor = 1'b1;
    spr_write = 1'b0;
    spr_read = 1'b0;
    spr_num = SPR_THROTTLE;
    spr_wdata = 32'h0000_0000;
    external_irq_enable = 1'b1;
    fetch_req = 1'b1;
    temp_c = 7'h00;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    settle(1);
    t_regs();
    t_throttle();
    t_single();
    t_dual();
    end_sim();
  end
  initial begin
    repeat (4000) @(posedge clock);
    bad_count++;
    end_sim();
  end
endmodule // taf_thermal_throttle_bench
`default_nettype wire
